//--- rtl/frst_top.sv
`timescale 1ns/1ps
`include "frst_defs.svh"

// Functional notes
// - A 56-bit counter counts only upward and runs freely with no start command.
// - It advances at the clock rate divided by a 3-bit divider field that resets to 2.
// - Power-on, watchdog, or soft reset with the timer request set clears and restarts it.
// - The hardware reset pin leaves the count and the divider field untouched.
// - The count windows are read-only and writes never change the count.
// - Reading any of windows zero to five copies the upper count bits into the capture.
// - Seven read-only 32-bit windows show ever higher slices of the count.
// - Two compare values, each on a chosen partial range, can raise an interrupt on match.
// - The clock control can disable the timer or halt it in debug suspend, reads still work.
module frst_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wdt_reset,
    input wire logic soft_reset,
    input wire logic timer_soft_reset_request,
    input wire logic hardware_reset_pin_n,
    input wire logic debug_suspend,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    frst_pkg::frst_state_t st_reg;
    frst_pkg::frst_state_t st_next;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_err;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    logic [1:0] hit;
    logic ctr_clear;
    logic hw_pin_active;
    logic suspended;
    logic enable;
    logic tick;
    logic win_lo_hit;
    logic [31:0] clc_view;
    logic [31:0] clc_new;

    // Register bus slave
    frst_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // Two compare units, each with its own slice of the compare control word
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_cmp
            frst_cmp_unit u_cmp (
                .aclk(aclk),
                .aresetn(aresetn),
                .count(st_reg.count),
                .cmp_value(gi == 0 ? st_reg.cmp0 : st_reg.cmp1),
                .start(st_reg.cmp_ctl[gi*`FRST_CMPCTL_STRIDE+`FRST_CMPCTL_START_LSB
                    +: `FRST_CMPCTL_FLD_W]),
                .size(st_reg.cmp_ctl[gi*`FRST_CMPCTL_STRIDE+`FRST_CMPCTL_SIZE_LSB
                    +: `FRST_CMPCTL_FLD_W]),
                .hit(hit[gi])
            );
        end
    endgenerate

    // Byte-lane merge of a bus write into a stored word
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
        input logic [31:0] new_val, input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                res[b*8 +: 8] = new_val[b*8 +: 8];
        end
        return res;
    endfunction

    // Decode of every mapped word; window writes are accepted but do nothing
    function automatic logic is_mapped(input logic [7:0] addr);
        logic hitm;
        hitm = (addr == `FRST_OFF_CLC) || (addr == `FRST_OFF_CAP);
        hitm = hitm || (addr == `FRST_OFF_CMP0) || (addr == `FRST_OFF_CMP1);
        hitm = hitm || (addr == `FRST_OFF_CMPCTL) || (addr == `FRST_OFF_IRQST);
        hitm = hitm || (addr == `FRST_OFF_IRQMSK);
        hitm = hitm || ((addr >= `FRST_OFF_WIN0) && (addr <= `FRST_OFF_WIN6)
            && (addr[1:0] == 2'h0));
        return hitm;
    endfunction

    assign wr_err = !is_mapped(wr_addr);
    assign rd_err = !is_mapped(rd_addr);

    // Counter clear sources; the pin is not among them
    assign ctr_clear = wdt_reset || (soft_reset && timer_soft_reset_request);
    assign hw_pin_active = !st_reg.hsync2;
    assign suspended = st_reg.sus_en && debug_suspend;
    // Divider zero gates the clock exactly like a disable
    assign enable = (st_reg.div != 3'h0) && !st_reg.dis_req && !suspended;
    assign tick = enable && (st_reg.presc >= (st_reg.div - 3'h1));
    // Only the six lower windows arm the capture, window six already holds the top
    assign win_lo_hit = (rd_addr >= `FRST_OFF_WIN0) && (rd_addr < `FRST_OFF_WIN6)
        && (rd_addr[1:0] == 2'h0);

    // Clock control as seen by software, status bits included
    always_comb
    begin
        clc_view = 32'h0;
        clc_view[`FRST_CLC_DIS_BIT] = st_reg.dis_req;
        clc_view[`FRST_CLC_DISS_BIT] = !enable;
        clc_view[`FRST_CLC_SUSEN_BIT] = st_reg.sus_en;
        clc_view[`FRST_CLC_SUSS_BIT] = suspended;
        clc_view[`FRST_CLC_DIV_LSB +: `FRST_DIV_W] = st_reg.div;
        clc_new = merge_bytes(clc_view, wr_data, wr_strb);
    end

    // Read mux; the data are taken from the same count that the capture copies
    always_comb
    begin
        rd_data = 32'h0;
        for (int k = 0; k < `FRST_WIN_LO_N; k++)
        begin
            if (rd_addr == `FRST_OFF_WIN0 + 8'(k * `FRST_WIN_STEP))
                rd_data = st_reg.count[k*`FRST_WIN_STEP +: 32];
        end
        case (rd_addr)
            `FRST_OFF_CLC: rd_data = clc_view;
            `FRST_OFF_WIN6: rd_data = {8'h0, st_reg.count[`FRST_HI_LSB +: `FRST_HI_W]};
            `FRST_OFF_CAP: rd_data = {8'h0, st_reg.cap};
            `FRST_OFF_CMP0: rd_data = st_reg.cmp0;
            `FRST_OFF_CMP1: rd_data = st_reg.cmp1;
            `FRST_OFF_CMPCTL: rd_data = st_reg.cmp_ctl;
            `FRST_OFF_IRQST: rd_data = {30'h0, st_reg.status};
            `FRST_OFF_IRQMSK: rd_data = {30'h0, st_reg.mask};
            default: ;
        endcase
    end

    // Next state of the timer
    always_comb
    begin
        st_next = st_reg;
        // Pin synchroniser, first stage feeds only the second
        st_next.hsync1 = hardware_reset_pin_n;
        st_next.hsync2 = st_reg.hsync1;
        // Prescaler and count; no path from the bus reaches the count
        if (tick)
        begin
            st_next.presc = 3'h0;
            st_next.count = st_reg.count + 56'h1;
        end
        else if (enable)
            st_next.presc = st_reg.presc + 3'h1;
        // Capture of the upper part on a low-window read
        if (rd_en && win_lo_hit)
            st_next.cap = st_reg.count[`FRST_HI_LSB +: `FRST_HI_W];
        // Software writes
        if (wr_en)
        begin
            case (wr_addr)
                `FRST_OFF_CLC:
                begin
                    st_next.dis_req = clc_new[`FRST_CLC_DIS_BIT];
                    st_next.sus_en = clc_new[`FRST_CLC_SUSEN_BIT];
                    st_next.div = clc_new[`FRST_CLC_DIV_LSB +: `FRST_DIV_W];
                end
                `FRST_OFF_CMP0: st_next.cmp0 = merge_bytes(st_reg.cmp0, wr_data, wr_strb);
                `FRST_OFF_CMP1: st_next.cmp1 = merge_bytes(st_reg.cmp1, wr_data, wr_strb);
                `FRST_OFF_CMPCTL:
                    st_next.cmp_ctl = merge_bytes(st_reg.cmp_ctl, wr_data, wr_strb)
                        & 32'h1f1f_1f1f; // Reserved bits read 0
                `FRST_OFF_IRQMSK:
                begin
                    if (wr_strb[0])
                        st_next.mask = wr_data[1:0];
                end
                default: ; // Windows and capture ignore writes
            endcase
        end
        // Sticky status: clear by writing one, a new hit in the same cycle wins
        if (wr_en && (wr_addr == `FRST_OFF_IRQST) && wr_strb[0])
            st_next.status = (st_reg.status & ~wr_data[1:0]) | hit;
        else
            st_next.status = st_reg.status | hit;
        // Hardware pin resets the control side but spares count and divider
        if (hw_pin_active)
        begin
            st_next.dis_req = 1'b0;
            st_next.sus_en = 1'b0;
            st_next.cmp0 = 32'h0;
            st_next.cmp1 = 32'h0;
            st_next.cmp_ctl = `FRST_CMPCTL_RST;
            st_next.status = 2'h0;
            st_next.mask = 2'h0;
        end
        // Watchdog or requested soft reset: clear, enable, count on at once
        if (ctr_clear)
        begin
            st_next.count = 56'h0;
            st_next.presc = 3'h0;
            st_next.div = `FRST_DIV_RST;
            st_next.dis_req = 1'b0;
            st_next.cap = 24'h0;
        end
    end

    // Power-on reset puts every field at its documented start value
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= '0;
            st_reg.div <= `FRST_DIV_RST;
            st_reg.cmp_ctl <= `FRST_CMPCTL_RST;
            st_reg.hsync1 <= 1'b1;
            st_reg.hsync2 <= 1'b1;
        end
        else
            st_reg <= st_next;
    end

    // Level interrupt, high while any unmasked status bit is set
    assign irq = |(st_reg.status & st_reg.mask);

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_count_up_only: assert property (!ctr_clear |=>
        ((st_reg.count == $past(st_reg.count)) || (st_reg.count == $past(st_reg.count) + 56'h1)))
        else $error("count moved other than by one upward");
    chk_clear_restarts: assert property (ctr_clear |=>
        (st_reg.count == 56'h0) ##2 (st_reg.count == 56'h1))
        else $error("cleared counter did not restart at half rate");
    chk_half_rate_tick: assert property (
        (tick && (st_reg.div == `FRST_DIV_RST) && !ctr_clear && !wr_en) |=> !tick)
        else $error("divide by two ticked on adjacent cycles");
    chk_pin_spares_count: assert property (
        (hw_pin_active && !ctr_clear && !wr_en) |=>
        ($stable(st_reg.div) && (st_reg.count >= $past(st_reg.count))))
        else $error("hardware pin disturbed count or divider");
    chk_cap_on_read: assert property ((rd_en && win_lo_hit && !ctr_clear) |=>
        (st_reg.cap == $past(st_reg.count[`FRST_HI_LSB +: `FRST_HI_W])))
        else $error("capture missed the upper count bits");
    chk_window_slice: assert property ((rd_en && (rd_addr == `FRST_OFF_WIN6)) |=>
        (s_axi_rdata == {8'h0, $past(st_reg.count[`FRST_HI_LSB +: `FRST_HI_W])}))
        else $error("top window shows wrong slice");
    chk_div_zero_holds: assert property (
        ((st_reg.div == 3'h0) && !ctr_clear) |=> $stable(st_reg.count))
        else $error("count moved with divider at zero");
    chk_suspend_holds: assert property ((suspended && !ctr_clear) |=>
        $stable(st_reg.count))
        else $error("count moved while suspended");
    chk_hit_sets_status: assert property ((hit[0] && !hw_pin_active) |=>
        st_reg.status[0])
        else $error("compare hit did not set status");
endmodule

//--- rtl/frst_defs.svh
`ifndef FRST_DEFS_SVH
`define FRST_DEFS_SVH

// Counter geometry
`define FRST_CNT_W 56
`define FRST_HI_LSB 32
`define FRST_HI_W 24
`define FRST_WIN_STEP 4
`define FRST_WIN_LO_N 6

// Register byte offsets
`define FRST_OFF_CLC 8'h00
`define FRST_OFF_WIN0 8'h10
`define FRST_OFF_WIN6 8'h28
`define FRST_OFF_CAP 8'h2c
`define FRST_OFF_CMP0 8'h30
`define FRST_OFF_CMP1 8'h34
`define FRST_OFF_CMPCTL 8'h38
`define FRST_OFF_IRQST 8'h3c
`define FRST_OFF_IRQMSK 8'h40

// Clock control fields
`define FRST_CLC_DIS_BIT 0
`define FRST_CLC_DISS_BIT 1
`define FRST_CLC_SUSEN_BIT 2
`define FRST_CLC_SUSS_BIT 3
`define FRST_CLC_DIV_LSB 8
`define FRST_DIV_W 3

// Compare control fields, one group of 16 bits per compare unit
`define FRST_CMPCTL_STRIDE 16
`define FRST_CMPCTL_SIZE_LSB 0
`define FRST_CMPCTL_START_LSB 8
`define FRST_CMPCTL_FLD_W 5

// Reset values
`define FRST_DIV_RST 3'h2
`define FRST_CMPCTL_RST 32'h001f_001f

// AXI responses
`define FRST_RESP_OKAY 2'h0
`define FRST_RESP_DECERR 2'h3

`endif

//--- rtl/frst_pkg.sv
`include "frst_defs.svh"

package frst_pkg;

    // Whole state of the timer core
    typedef struct packed {
        logic [`FRST_CNT_W-1:0] count;
        logic [`FRST_DIV_W-1:0] presc;
        logic [`FRST_DIV_W-1:0] div;
        logic dis_req;
        logic sus_en;
        logic [`FRST_HI_W-1:0] cap;
        logic [31:0] cmp0;
        logic [31:0] cmp1;
        logic [31:0] cmp_ctl;
        logic [1:0] status;
        logic [1:0] mask;
        logic hsync1;
        logic hsync2;
    } frst_state_t;

    // State of the bus slave
    typedef struct packed {
        logic aw_full;
        logic w_full;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } frst_axil_state_t;

    // State of one compare unit
    typedef struct packed {
        logic match;
        logic hit;
    } frst_cmp_state_t;

endpackage

//--- rtl/frst_cmp_unit.sv
`timescale 1ns/1ps
`include "frst_defs.svh"

module frst_cmp_unit (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [`FRST_CNT_W-1:0] count,
    input wire logic [31:0] cmp_value,
    input wire logic [`FRST_CMPCTL_FLD_W-1:0] start,
    input wire logic [`FRST_CMPCTL_FLD_W-1:0] size,
    output logic hit
);
    frst_pkg::frst_cmp_state_t st_reg;
    frst_pkg::frst_cmp_state_t st_next;
    logic [`FRST_CNT_W-1:0] shifted;
    logic [31:0] sel_mask;

    // Partial-range compare: size+1 bits of the count from bit start upward
    always_comb
    begin
        shifted = count >> start;
        for (int i = 0; i < 32; i++)
        begin
            sel_mask[i] = (5'(i) <= size);
        end
        st_next.match = (((shifted[31:0] ^ cmp_value) & sel_mask) == 32'h0);
        // Only the first cycle of a match fires, a held count must not refire
        st_next.hit = st_next.match & ~st_reg.match;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign hit = st_reg.hit;

    chk_hit_single_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
        hit |=> !hit)
        else $error("compare hit lasted more than one cycle");
endmodule

//--- rtl/frst_axil_slave.sv
`timescale 1ns/1ps
`include "frst_defs.svh"

module frst_axil_slave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [7:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic rd_en,
    output logic [7:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    frst_pkg::frst_axil_state_t st_reg;
    frst_pkg::frst_axil_state_t st_next;

    // Address and data are held until both are present, in either order
    assign s_axi_awready = !st_reg.aw_full && !st_reg.bvalid;
    assign s_axi_wready = !st_reg.w_full && !st_reg.bvalid;
    assign wr_en = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
    assign wr_addr = st_reg.awaddr;
    assign wr_data = st_reg.wdata;
    assign wr_strb = st_reg.wstrb;
    // One read in flight; the core sees the read in the handshake cycle
    assign s_axi_arready = !st_reg.rvalid;
    assign rd_en = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr;

    always_comb
    begin
        st_next = st_reg;
        if (s_axi_awvalid && s_axi_awready)
        begin
            st_next.aw_full = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            st_next.w_full = 1'b1;
            st_next.wdata = s_axi_wdata;
            st_next.wstrb = s_axi_wstrb;
        end
        if (wr_en)
        begin
            st_next.aw_full = 1'b0;
            st_next.w_full = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = wr_err ? `FRST_RESP_DECERR : `FRST_RESP_OKAY;
        end
        else if (st_reg.bvalid && s_axi_bready)
            st_next.bvalid = 1'b0;
        if (rd_en)
        begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rd_data;
            st_next.rresp = rd_err ? `FRST_RESP_DECERR : `FRST_RESP_OKAY;
        end
        else if (st_reg.rvalid && s_axi_rready)
            st_next.rvalid = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;

    chk_bresp_held_stable: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
        else $error("write response dropped before bready");
    chk_rdata_held_stable: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
        else $error("read data changed before rready");
endmodule

//--- bench/test_free_running_system_timer.sv
`timescale 1ns/1ps
`include "frst_defs.svh"

module test_free_running_system_timer;
    logic aclk, aresetn, wdt_reset, soft_reset, timer_soft_reset_request;
    logic hardware_reset_pin_n, debug_suspend, irq;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd, v, c0, ar_cyc, cyc;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    int n_mismatch, comparisons;

    // Ordinary register cases: address, write data, write resp, read data, read mask, read resp
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] wd;
        logic [1:0] wr;
        logic [31:0] rd;
        logic [31:0] m;
        logic [1:0] rr;
    } frst_row_t;
    frst_row_t rows [9] = '{
        '{`FRST_OFF_CMP0, 32'h1234_5678, 2'h0, 32'h1234_5678, 32'hffff_ffff, 2'h0},
        '{`FRST_OFF_CMP1, 32'hffff_ffff, 2'h0, 32'hffff_ffff, 32'hffff_ffff, 2'h0},
        '{`FRST_OFF_CMPCTL, 32'hffff_ffff, 2'h0, 32'h1f1f_1f1f, 32'hffff_ffff, 2'h0},
        '{`FRST_OFF_IRQMSK, 32'hffff_ffff, 2'h0, 32'h0000_0003, 32'hffff_ffff, 2'h0},
        '{`FRST_OFF_CLC, 32'h0000_0100, 2'h0, 32'h0000_0100, 32'hffff_ffff, 2'h0},
        '{`FRST_OFF_WIN0, 32'hffff_ffff, 2'h0, 32'h0, 32'h0, 2'h0},
        '{`FRST_OFF_WIN6, 32'hffff_ffff, 2'h0, 32'h0, 32'h0, 2'h0},
        '{`FRST_OFF_CAP, 32'hffff_ffff, 2'h0, 32'h0, 32'h0, 2'h0},
        '{8'h44, 32'hffff_ffff, `FRST_RESP_DECERR, 32'h0, 32'hffff_ffff, `FRST_RESP_DECERR}
    };

    frst_top DUT (.aclk, .aresetn, .wdt_reset, .soft_reset, .timer_soft_reset_request,
        .hardware_reset_pin_n, .debug_suspend, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

    // Free-running clock, 10 ns period
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Cycle count lets rate checks avoid guessing the bus latency
    always @(posedge aclk) cyc <= cyc + 32'h1;

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // A bounded wait that ran out ends the run as a failure
    task automatic out_of_time(input int n);
        if (n >= 200)
        begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic aw, w;
        n = 0;
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // Each channel is released only at the edge that takes it
        do
        begin
            @(posedge aclk);
            n++;
            if (!aw && s_axi_awready)
            begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready)
            begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end while (!(aw && w) && n < 200);
        do
        begin
            @(posedge aclk);
            n++;
        end while (!s_axi_bvalid && n < 200);
        r = s_axi_bresp;
        out_of_time(n);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
        end while (!s_axi_arready && n < 200);
        ar_cyc = cyc;
        s_axi_arvalid <= 1'b0;
        do
        begin
            @(posedge aclk);
            n++;
        end while (!s_axi_rvalid && n < 200);
        d = s_axi_rdata;
        r = s_axi_rresp;
        out_of_time(n);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wr_reg(a, d, rs);
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a, rd, rs);
        check_data(rd, exp);
    endtask

    // Two back-to-back reads of the low window must agree while counting is held
    task automatic chk_hold();
        rd_reg(`FRST_OFF_WIN0, v, rs);
        chk_rd(`FRST_OFF_WIN0, v);
    endtask

    initial
    begin
        {wdt_reset, soft_reset, timer_soft_reset_request, debug_suspend} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        hardware_reset_pin_n = 1'b1;
        cyc = 32'h0;
        aresetn = 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (rows[i])
        begin
            wr_reg(rows[i].a, rows[i].wd, rs);
            check_resp(rs, rows[i].wr);
            rd_reg(rows[i].a, rd, rs);
            check_data(rd & rows[i].m, rows[i].rd);
            check_resp(rs, rows[i].rr);
        end
        // Second power-on reset brings back the reset values
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_rd(`FRST_OFF_CLC, {21'h0, `FRST_DIV_RST, 8'h00});
        chk_rd(`FRST_OFF_CMPCTL, `FRST_CMPCTL_RST);
        chk_rd(`FRST_OFF_IRQMSK, 32'h0);
        // Divide by one counts every cycle, divide by four every fourth
        wr(`FRST_OFF_CLC, 32'h0000_0100);
        rd_reg(`FRST_OFF_WIN0, v, rs);
        c0 = ar_cyc;
        rd_reg(`FRST_OFF_WIN0, rd, rs);
        check_data(rd, v + ar_cyc - c0);
        wr(`FRST_OFF_CLC, 32'h0000_0400);
        rd_reg(`FRST_OFF_WIN0, v, rs);
        c0 = ar_cyc;
        rd_reg(`FRST_OFF_WIN0, rd, rs);
        c0 = ar_cyc - c0;
        check_data({31'h0, (rd - v) * 4 + 3 >= c0 && (rd - v) * 4 <= c0 + 3}, 32'h1);
        // Divider zero stops the count; windows and capture read from the held value
        wr(`FRST_OFF_CLC, 32'h0);
        chk_rd(`FRST_OFF_CLC, 32'h0000_0002);
        chk_hold();
        for (int k = 1; k < 6; k++)
            chk_rd(`FRST_OFF_WIN0 + 8'(4 * k), v >> (4 * k));
        chk_rd(`FRST_OFF_WIN6, 32'h0);
        chk_rd(`FRST_OFF_CAP, 32'h0);
        wr(`FRST_OFF_WIN0, 32'hffff_ffff);
        chk_rd(`FRST_OFF_WIN0, v);
        // Soft reset without its request bit must leave the count alone
        soft_reset <= 1'b1;
        @(posedge aclk);
        soft_reset <= 1'b0;
        chk_rd(`FRST_OFF_WIN0, v);
        {soft_reset, timer_soft_reset_request} <= 2'h3;
        @(posedge aclk);
        {soft_reset, timer_soft_reset_request} <= 2'h0;
        chk_rd(`FRST_OFF_CLC, 32'h0000_0200);
        rd_reg(`FRST_OFF_WIN0, rd, rs);
        check_data({31'h0, rd > 0 && rd < 20}, 32'h1);
        wr(`FRST_OFF_CLC, 32'h0);
        wdt_reset <= 1'b1;
        @(posedge aclk);
        wdt_reset <= 1'b0;
        chk_rd(`FRST_OFF_CLC, 32'h0000_0200);
        rd_reg(`FRST_OFF_WIN0, rd, rs);
        check_data({31'h0, rd > 0 && rd < 20}, 32'h1);
        // Disable request and debug suspend both hold the count
        wr(`FRST_OFF_CLC, 32'h0000_0101);
        chk_rd(`FRST_OFF_CLC, 32'h0000_0103);
        chk_hold();
        wr(`FRST_OFF_CLC, 32'h0000_0104);
        debug_suspend <= 1'b1;
        chk_rd(`FRST_OFF_CLC, 32'h0000_010e);
        chk_hold();
        debug_suspend <= 1'b0;
        // Full-range match on unit 0, four-bit partial match on unit 1
        wr(`FRST_OFF_CLC, 32'h0000_0100);
        wr(`FRST_OFF_CMPCTL, 32'h0403_001f);
        wr(`FRST_OFF_CMP1, 32'h0000_0005);
        rd_reg(`FRST_OFF_WIN0, v, rs);
        wr(`FRST_OFF_CMP0, v + 32'h12c);
        wr(`FRST_OFF_IRQST, 32'h0000_0003);
        wr(`FRST_OFF_IRQMSK, 32'h0000_0001);
        check_data({31'h0, irq}, 32'h0);
        for (int n = 0; n < 600 && irq !== 1'b1; n++)
            @(posedge aclk);
        check_data({31'h0, irq}, 32'h1);
        chk_rd(`FRST_OFF_IRQST, 32'h0000_0003);
        wr(`FRST_OFF_IRQST, 32'h0000_0001);
        check_data({31'h0, irq}, 32'h0);
        wr(`FRST_OFF_IRQMSK, 32'h0000_0002);
        check_data({31'h0, irq}, 32'h1);
        // Hardware pin keeps count and divider, clears compare setup
        wr(`FRST_OFF_CLC, 32'h0000_0300);
        rd_reg(`FRST_OFF_WIN0, v, rs);
        hardware_reset_pin_n <= 1'b0;
        repeat (5) @(posedge aclk);
        hardware_reset_pin_n <= 1'b1;
        repeat (4) @(posedge aclk);
        chk_rd(`FRST_OFF_CLC, 32'h0000_0300);
        chk_rd(`FRST_OFF_CMPCTL, `FRST_CMPCTL_RST);
        rd_reg(`FRST_OFF_WIN0, rd, rs);
        check_data({31'h0, rd > v}, 32'h1);
        check_data({31'h0, irq}, 32'h0);
        give_verdict();
    end
endmodule
